//--- src/ppr_pkg.sv
// shared constants and carrier types of the pin remap fabric
package ppr_pkg;

  localparam int unsigned FIELD_W       = 5;
  localparam int unsigned NUM_IN_FIELDS = 23;
  localparam int unsigned MAX_PINS      = 32;
  localparam int unsigned SYNC_STAGES   = 3;
  localparam int unsigned CODE_SPACE    = 32;

  localparam logic [4:0]  IN_ROUTE_RST  = 5'h1F;
  localparam logic [4:0]  OUT_CODE_NULL = 5'h00;

  // output function codes
  localparam logic [4:0]  CODE_CMP_ONE  = 5'h01;
  localparam logic [4:0]  CODE_CMP_TWO  = 5'h02;
  localparam logic [4:0]  CODE_U1_TX    = 5'h03;
  localparam logic [4:0]  CODE_U1_RTS   = 5'h04;
  localparam logic [4:0]  CODE_U2_TX    = 5'h05;
  localparam logic [4:0]  CODE_U2_RTS   = 5'h06;
  localparam logic [4:0]  CODE_S1_DO    = 5'h07;
  localparam logic [4:0]  CODE_S1_CK    = 5'h08;
  localparam logic [4:0]  CODE_S1_SS    = 5'h09;
  localparam logic [4:0]  CODE_S2_DO    = 5'h0A;
  localparam logic [4:0]  CODE_S2_CK    = 5'h0B;
  localparam logic [4:0]  CODE_S2_SS    = 5'h0C;
  localparam logic [4:0]  CODE_OC_ONE   = 5'h12;
  localparam logic [4:0]  CODE_OC_FIVE  = 5'h16;

  // one bit per code that has a peripheral behind it
  localparam logic [31:0] OUT_CODE_MASK = 32'h007C_1FFE;

  // input field indices, ext_irq_one_in is index 0, spi_two_select_in index 22
  localparam logic [4:0]  IN_IDX_U1_RX  = 5'h0D;
  localparam logic [4:0]  IN_IDX_LAST   = 5'h16;

  // peripheral outputs, one bit each
  typedef struct packed {
    logic compare_five_out;
    logic compare_four_out;
    logic compare_three_out;
    logic compare_two_out;
    logic compare_one_out;
    logic spi_two_select_out;
    logic spi_two_clock_out;
    logic spi_two_data_out;
    logic spi_one_select_out;
    logic spi_one_clock_out;
    logic spi_one_data_out;
    logic uart_two_request_send_out;
    logic uart_two_transmit_out;
    logic uart_one_request_send_out;
    logic uart_one_transmit_out;
    logic comparator_two_out;
    logic comparator_one_out;
  } ppr_periph_out_s;

  // peripheral inputs, last field sits at bit 0
  typedef struct packed {
    logic spi_two_select_in;
    logic spi_two_clock_in;
    logic spi_two_data_in;
    logic spi_one_select_in;
    logic spi_one_clock_in;
    logic spi_one_data_in;
    logic uart_two_clear_send_in;
    logic uart_two_receive_in;
    logic uart_one_clear_send_in;
    logic uart_one_receive_in;
    logic compare_fault_b_in;
    logic compare_fault_a_in;
    logic capture_five_in;
    logic capture_four_in;
    logic capture_three_in;
    logic capture_two_in;
    logic capture_one_in;
    logic timer_five_ext_clk;
    logic timer_four_ext_clk;
    logic timer_three_ext_clk;
    logic timer_two_ext_clk;
    logic ext_irq_two_in;
    logic ext_irq_one_in;
  } ppr_periph_in_s;

  // infrared encoder baud clock per uart
  typedef struct packed {
    logic [1:0] enable;
    logic [1:0] baud_clk;
  } ppr_ir_s;

endpackage

//--- src/ppr_remap_matrix.sv
// pin remap fabric: per-peripheral input routing and per-pin output routing
//
// What this block does
// - A selected remap output beats port latch and parallel port on the pin.
// - Dedicated special outputs on a pin beat any remap output there.
// - Input routing never touches a pin's driver; direction bit, fixed owner or a remap output code does.
// - A routed input gets the pin's digital level when the pin is digital.
// - Analog use of a pin disables every remap input routed from it.
// - Input routing and output routing live in separate register sets.
// - Input routing is per peripheral, one 5-bit field per peripheral input.
// - Field value n connects remap pin n to that peripheral input.
// - Twenty-three input fields: irqs, timer clocks, captures, faults, uarts, spis.
// - Output routing is per pin, one 5-bit function code per pin.
// - Code zero leaves the pin disconnected from all remap outputs.
// - Codes 1-2 comparators; 3-6 uart1 tx, rts, uart2 tx, rts.
// - Codes 7-9 spi1 data, clock, select; 10-12 same for spi2.
// - Codes 18 to 22 select compare outputs one to five.
// - Every pin's output code resets to the null code.
// - Infrared encoder baud clock leaves through the uart request-send selection.
// - Structure makes contention impossible; no further lockout on mapping choices.
// - One pin may feed many inputs; one output may drive many pins.
// - All input fields reset to 31, even if pin 31 does not exist.
// - While locked, route writes complete but change nothing.
`timescale 1ns/10ps

module ppr_remap_matrix
  import ppr_pkg::*;
#(
  parameter int unsigned NUM_PINS   = 26,
  parameter logic        IDLE_LEVEL = 1'b0
) (
  // clock and reset
  input  wire logic                          CLK_I,
  input  wire logic                          RESET_N_I,
  // route configuration
  input  wire logic                          ROUTE_WRITE_LOCK_I,
  input  wire logic                          IN_ROUTE_WR_I,
  input  wire logic [FIELD_W-1:0]            IN_ROUTE_IDX_I,
  input  wire logic [FIELD_W-1:0]            IN_ROUTE_DATA_I,
  input  wire logic                          OUT_ROUTE_WR_I,
  input  wire logic [FIELD_W-1:0]            OUT_ROUTE_IDX_I,
  input  wire logic [FIELD_W-1:0]            OUT_ROUTE_DATA_I,
  output      logic [NUM_IN_FIELDS*FIELD_W-1:0] IN_ROUTE_O,
  output      logic [NUM_PINS*FIELD_W-1:0]   OUT_ROUTE_O,
  // peripheral side
  input  wire ppr_periph_out_s               PERIPH_OUT_I,
  input  wire ppr_ir_s                       IR_I,
  output      ppr_periph_in_s                PERIPH_IN_O,
  // fixed pin owners
  input  wire logic [NUM_PINS-1:0]           PIN_DIRECTION_BIT_I,
  input  wire logic [NUM_PINS-1:0]           PORT_LATCH_I,
  input  wire logic [NUM_PINS-1:0]           PARALLEL_HOST_PORT_FN_OE_I,
  input  wire logic [NUM_PINS-1:0]           PARALLEL_HOST_PORT_FN_DATA_I,
  input  wire logic [NUM_PINS-1:0]           SPECIAL_OE_I,
  input  wire logic [NUM_PINS-1:0]           SPECIAL_DATA_I,
  input  wire logic [NUM_PINS-1:0]           ANALOG_EN_I,
  // remap pins
  input  wire logic [NUM_PINS-1:0]           REMAP_PIN_N_I,
  output      logic [NUM_PINS-1:0]           REMAP_PIN_N_O,
  output      logic [NUM_PINS-1:0]           REMAP_PIN_N_OE_O
);

  if (NUM_PINS < 1 || NUM_PINS > MAX_PINS) begin : g_bad_pins
    $error("NUM_PINS must lie between 1 and 32");
  end

  // route storage
  logic [FIELD_W-1:0]        in_route_r  [NUM_IN_FIELDS];
  logic [FIELD_W-1:0]        out_route_r [NUM_PINS];
  logic [NUM_IN_FIELDS-1:0]  in_lvl_r;
  logic [NUM_IN_FIELDS-1:0]  in_lvl_nxt;
  logic [NUM_PINS-1:0]       pin_out_r;
  logic [NUM_PINS-1:0]       pin_out_nxt;
  logic [NUM_PINS-1:0]       pin_oe_r;
  logic [NUM_PINS-1:0]       pin_oe_nxt;

  // pin input synchroniser
  logic [NUM_PINS-1:0]       sync1_r;
  logic [NUM_PINS-1:0]       sync2_r;
  logic [NUM_PINS-1:0]       sync3_r;
  logic [NUM_PINS-1:0]       pin_lvl_r;
  logic [NUM_PINS-1:0]       pin_lvl_nxt;

  // decode of writes
  wire                       in_wr_ok;
  wire                       out_wr_ok;
  wire [MAX_PINS-1:0]        pin_lvl_w;
  wire [MAX_PINS-1:0]        pin_analog_w;
  wire [MAX_PINS-1:0]        pin_exists_w;
  wire [CODE_SPACE-1:0]      src_w;
  wire                       rts_one_w;
  wire                       rts_two_w;

  assign in_wr_ok  = IN_ROUTE_WR_I && !ROUTE_WRITE_LOCK_I
                     && (IN_ROUTE_IDX_I <= IN_IDX_LAST);
  assign out_wr_ok = OUT_ROUTE_WR_I && !ROUTE_WRITE_LOCK_I
                     && (32'(OUT_ROUTE_IDX_I) < NUM_PINS);

  assign pin_lvl_w    = MAX_PINS'(pin_lvl_r);
  assign pin_analog_w = MAX_PINS'(ANALOG_EN_I);
  assign pin_exists_w = MAX_PINS'({NUM_PINS{1'b1}});

  // infrared baud clock rides on the request-send code
  assign rts_one_w = IR_I.enable[0] ? IR_I.baud_clk[0]
                                    : PERIPH_OUT_I.uart_one_request_send_out;
  assign rts_two_w = IR_I.enable[1] ? IR_I.baud_clk[1]
                                    : PERIPH_OUT_I.uart_two_request_send_out;

  // source vector indexed by function code, gaps tied low
  assign src_w = {9'h0_00,
                  PERIPH_OUT_I.compare_five_out,
                  PERIPH_OUT_I.compare_four_out,
                  PERIPH_OUT_I.compare_three_out,
                  PERIPH_OUT_I.compare_two_out,
                  PERIPH_OUT_I.compare_one_out,
                  5'h0_0,
                  PERIPH_OUT_I.spi_two_select_out,
                  PERIPH_OUT_I.spi_two_clock_out,
                  PERIPH_OUT_I.spi_two_data_out,
                  PERIPH_OUT_I.spi_one_select_out,
                  PERIPH_OUT_I.spi_one_clock_out,
                  PERIPH_OUT_I.spi_one_data_out,
                  rts_two_w,
                  PERIPH_OUT_I.uart_two_transmit_out,
                  rts_one_w,
                  PERIPH_OUT_I.uart_one_transmit_out,
                  PERIPH_OUT_I.comparator_two_out,
                  PERIPH_OUT_I.comparator_one_out,
                  1'b0};

  // pin synchroniser, a change counts once stages two and three agree
  assign pin_lvl_nxt = (sync2_r & sync3_r) | (pin_lvl_r & (sync2_r | sync3_r));

  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      sync1_r   <= '0;
      sync2_r   <= '0;
      sync3_r   <= '0;
      pin_lvl_r <= '0;
    end else begin
      sync1_r   <= REMAP_PIN_N_I;
      sync2_r   <= sync1_r;
      sync3_r   <= sync2_r;
      pin_lvl_r <= pin_lvl_nxt;
    end
  end

  // input routing, one field per peripheral input
  for (genvar i = 0; i < NUM_IN_FIELDS; i++) begin : g_in
    wire [FIELD_W-1:0] sel_w = in_route_r[i];
    wire               hit_w = (IN_ROUTE_IDX_I == FIELD_W'(i)) && in_wr_ok;

    // missing pin or analog pin gives the idle level
    assign in_lvl_nxt[i] = (pin_exists_w[sel_w] && !pin_analog_w[sel_w])
                           ? pin_lvl_w[sel_w] : IDLE_LEVEL;

    always_ff @(posedge CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
        in_route_r[i] <= IN_ROUTE_RST;
      end else if (hit_w) begin
        in_route_r[i] <= IN_ROUTE_DATA_I;
      end
    end

    assign IN_ROUTE_O[i*FIELD_W +: FIELD_W] = in_route_r[i];
  end

  // output routing, one code per pin
  for (genvar p = 0; p < NUM_PINS; p++) begin : g_out
    wire [FIELD_W-1:0] code_w  = out_route_r[p];
    wire               remap_w = OUT_CODE_MASK[code_w];
    wire               hit_w   = (OUT_ROUTE_IDX_I == FIELD_W'(p)) && out_wr_ok;

    // priority: special, remap, parallel port, port latch
    assign pin_out_nxt[p] = SPECIAL_OE_I[p]               ? SPECIAL_DATA_I[p]
                          : remap_w                       ? src_w[code_w]
                          : PARALLEL_HOST_PORT_FN_OE_I[p] ? PARALLEL_HOST_PORT_FN_DATA_I[p]
                          : PORT_LATCH_I[p];
    // driver enable never depends on input routing
    assign pin_oe_nxt[p]  = SPECIAL_OE_I[p] || remap_w
                          || PARALLEL_HOST_PORT_FN_OE_I[p]
                          || !PIN_DIRECTION_BIT_I[p];

    always_ff @(posedge CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
        out_route_r[p] <= OUT_CODE_NULL;
      end else if (hit_w) begin
        out_route_r[p] <= OUT_ROUTE_DATA_I;
      end
    end

    assign OUT_ROUTE_O[p*FIELD_W +: FIELD_W] = out_route_r[p];
  end

  // registered pin drive and peripheral inputs
  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      pin_out_r <= '0;
      pin_oe_r  <= '0;
      in_lvl_r  <= {NUM_IN_FIELDS{IDLE_LEVEL}};
    end else begin
      pin_out_r <= pin_out_nxt;
      pin_oe_r  <= pin_oe_nxt;
      in_lvl_r  <= in_lvl_nxt;
    end
  end

  assign REMAP_PIN_N_O    = pin_out_r;
  assign REMAP_PIN_N_OE_O = pin_oe_r;
  assign PERIPH_IN_O      = ppr_periph_in_s'(in_lvl_r);

endmodule // ppr_remap_matrix

//--- testbench/ppr_pad_model.sv
// pad model: resolves each remap pin from the fabric and an outside driver
`timescale 1ns/10ps
module ppr_pad_model #(
  parameter int unsigned N = 26
) (
  // fabric side
  input  wire logic [N-1:0] oe_i,
  input  wire logic [N-1:0] dout_i,
  // outside driver
  input  wire logic [N-1:0] ext_i,
  output      logic [N-1:0] pin_o
);
  assign pin_o = (oe_i & dout_i) | (~oe_i & ext_i);
endmodule  // ppr_pad_model

//--- testbench/ppr_remap_checker.sv
// port assertions of the pin remap fabric
`timescale 1ns/10ps
module ppr_remap_checker
  import ppr_pkg::*;
#(
  parameter int unsigned NUM_PINS   = 26,
  parameter logic        IDLE_LEVEL = 1'b0
) (
  // watched ports
  input wire logic                             CLK_I,
  input wire logic                             RESET_N_I,
  input wire logic                             ROUTE_WRITE_LOCK_I,
  input wire logic                             IN_ROUTE_WR_I,
  input wire logic [FIELD_W-1:0]               IN_ROUTE_IDX_I,
  input wire logic [FIELD_W-1:0]               IN_ROUTE_DATA_I,
  input wire logic [NUM_IN_FIELDS*FIELD_W-1:0] IN_ROUTE_O,
  input wire logic [NUM_PINS*FIELD_W-1:0]      OUT_ROUTE_O,
  input wire ppr_periph_out_s                  PERIPH_OUT_I,
  input wire ppr_ir_s                          IR_I,
  input wire ppr_periph_in_s                   PERIPH_IN_O,
  input wire logic [NUM_PINS-1:0]              PIN_DIRECTION_BIT_I,
  input wire logic [NUM_PINS-1:0]              PARALLEL_HOST_PORT_FN_OE_I,
  input wire logic [NUM_PINS-1:0]              SPECIAL_OE_I,
  input wire logic [NUM_PINS-1:0]              SPECIAL_DATA_I,
  input wire logic [NUM_PINS-1:0]              ANALOG_EN_I,
  input wire logic [NUM_PINS-1:0]              REMAP_PIN_N_I,
  input wire logic [NUM_PINS-1:0]              REMAP_PIN_N_O,
  input wire logic [NUM_PINS-1:0]              REMAP_PIN_N_OE_O
);
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RESET_N_I);
  wire logic [4:0] code0 = OUT_ROUTE_O[4:0];
  wire logic [4:0] fld0  = IN_ROUTE_O[4:0];
  logic [4:0]      idx_r;
  always_ff @(posedge CLK_I) idx_r <= IN_ROUTE_IDX_I;
  sequence s_pin0_settled;
    (fld0 == 5'h00 && !ANALOG_EN_I[0] && $stable(REMAP_PIN_N_I[0]))[*6];
  endsequence
  a_special_wins: assert property (SPECIAL_OE_I[0] |=>
    REMAP_PIN_N_OE_O[0] && REMAP_PIN_N_O[0] == $past(SPECIAL_DATA_I[0])) else $error("pin 0 lost");
  a_remap_beats_port: assert property ((code0 == CODE_U1_TX && !SPECIAL_OE_I[0]) |=>
    REMAP_PIN_N_OE_O[0] && REMAP_PIN_N_O[0] == $past(PERIPH_OUT_I.uart_one_transmit_out))
    else $error("tx not on pin 0");
  a_null_undriven: assert property ((!OUT_CODE_MASK[code0] && !SPECIAL_OE_I[0] &&
    !PARALLEL_HOST_PORT_FN_OE_I[0]) |=> REMAP_PIN_N_OE_O[0] == !$past(PIN_DIRECTION_BIT_I[0]))
    else $error("null code drives pin 0");
  a_ir_baud_out: assert property ((code0 == CODE_U1_RTS && IR_I.enable[0] &&
    !SPECIAL_OE_I[0]) |=> REMAP_PIN_N_O[0] == $past(IR_I.baud_clk[0])) else $error("baud lost");
  a_lock_holds: assert property (ROUTE_WRITE_LOCK_I |=>
    $stable(IN_ROUTE_O) && $stable(OUT_ROUTE_O)) else $error("locked route changed");
  a_write_lands: assert property ((IN_ROUTE_WR_I && !ROUTE_WRITE_LOCK_I &&
    IN_ROUTE_IDX_I <= IN_IDX_LAST) |=> IN_ROUTE_O[idx_r*5 +: 5] == $past(IN_ROUTE_DATA_I))
    else $error("input field not written");
  a_analog_idle: assert property ((ANALOG_EN_I[0] && fld0 == 5'h00) |=>
    PERIPH_IN_O.ext_irq_one_in == IDLE_LEVEL) else $error("analog pin feeds input");
  a_missing_idle: assert property ((fld0 >= NUM_PINS) |=>
    PERIPH_IN_O.ext_irq_one_in == IDLE_LEVEL) else $error("missing pin not idle");
  a_pin_follows: assert property (s_pin0_settled |=>
    PERIPH_IN_O.ext_irq_one_in == $past(REMAP_PIN_N_I[0])) else $error("pin 0 level lost");
endmodule  // ppr_remap_checker

bind ppr_remap_matrix ppr_remap_checker #(.NUM_PINS(NUM_PINS), .IDLE_LEVEL(IDLE_LEVEL)) u_chk (
  .CLK_I, .RESET_N_I, .ROUTE_WRITE_LOCK_I, .IN_ROUTE_WR_I, .IN_ROUTE_IDX_I, .IN_ROUTE_DATA_I,
  .IN_ROUTE_O, .OUT_ROUTE_O, .PERIPH_OUT_I, .IR_I, .PERIPH_IN_O, .PIN_DIRECTION_BIT_I,
  .PARALLEL_HOST_PORT_FN_OE_I, .SPECIAL_OE_I, .SPECIAL_DATA_I, .ANALOG_EN_I, .REMAP_PIN_N_I,
  .REMAP_PIN_N_O, .REMAP_PIN_N_OE_O);

//--- testbench/testbench.sv
// self-checking bench of the pin remap fabric
`timescale 1ns/10ps
module testbench;
  import ppr_pkg::*;
  localparam int unsigned NP = 26;
  logic clk = 1'b0, rst_n = 1'b0, lock = 1'b0, in_wr = 1'b0, out_wr = 1'b0;
  logic [4:0] in_idx = '0, in_dat = '0, out_idx = '0, out_dat = '0, fld [23], codes [NP];
  logic [114:0] in_route;
  logic [NP*5-1:0] out_route;
  ppr_periph_out_s po = '0;
  ppr_ir_s ir = '0;
  ppr_periph_in_s pin_in;
  logic [NP-1:0] dir = '1, latch = '0, par_oe = '0, par_d = '0, sp_oe = '0, sp_d = '0;
  logic [NP-1:0] ana = '0, ext = '0, pad, dout, oe, e_oe, e_d;
  logic [22:0] e_in;
  logic [1:0] r;
  int n_errors = 0, checks_done = 0;
  always #50 clk = ~clk;
  ppr_remap_matrix #(.NUM_PINS(NP), .IDLE_LEVEL(1'b0)) DUT (.CLK_I(clk), .RESET_N_I(rst_n),
    .ROUTE_WRITE_LOCK_I(lock), .IN_ROUTE_WR_I(in_wr), .IN_ROUTE_IDX_I(in_idx),
    .IN_ROUTE_DATA_I(in_dat), .OUT_ROUTE_WR_I(out_wr), .OUT_ROUTE_IDX_I(out_idx),
    .OUT_ROUTE_DATA_I(out_dat), .IN_ROUTE_O(in_route), .OUT_ROUTE_O(out_route),
    .PERIPH_OUT_I(po), .IR_I(ir), .PERIPH_IN_O(pin_in), .PIN_DIRECTION_BIT_I(dir),
    .PORT_LATCH_I(latch), .PARALLEL_HOST_PORT_FN_OE_I(par_oe), .PARALLEL_HOST_PORT_FN_DATA_I(par_d),
    .SPECIAL_OE_I(sp_oe), .SPECIAL_DATA_I(sp_d), .ANALOG_EN_I(ana), .REMAP_PIN_N_I(pad),
    .REMAP_PIN_N_O(dout), .REMAP_PIN_N_OE_O(oe));
  ppr_pad_model #(.N(NP)) u_pad (.oe_i(oe), .dout_i(dout), .ext_i(ext), .pin_o(pad));
  task give_verdict;
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task check(input logic [159:0] seen, input logic [159:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task wr_in(input int i, input logic [4:0] n);
    @(negedge clk); in_wr = 1'b1; in_idx = 5'(i); in_dat = n;
    if (!lock) fld[i] = n;
    @(negedge clk); in_wr = 1'b0;
    check(in_route[i*5 +: 5], fld[i]);
  endtask
  task wr_out(input int p, input logic [4:0] c);
    @(negedge clk); out_wr = 1'b1; out_idx = 5'(p); out_dat = c;
    if (!lock) codes[p] = c;
    @(negedge clk); out_wr = 1'b0;
    check(out_route[p*5 +: 5], codes[p]);
  endtask
  function automatic logic [1:0] remap(input logic [4:0] c);  // drive flag and level
    if (c == CODE_U1_RTS && ir.enable[0]) return {1'b1, ir.baud_clk[0]};
    if (c == CODE_U2_RTS && ir.enable[1]) return {1'b1, ir.baud_clk[1]};
    if (c >= 5'h01 && c <= 5'h0C) return {1'b1, po[c-1]};
    if (c >= 5'h12 && c <= 5'h16) return {1'b1, po[c-6]};
    return 2'b00;
  endfunction
  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    give_verdict;
  end
  initial begin
    void'($urandom(32'h5ec7a7f0));
    foreach (fld[i]) fld[i] = 5'h1F;
    foreach (codes[p]) codes[p] = 5'h00;
    repeat (16) @(negedge clk);
    rst_n = 1'b1;
    @(negedge clk);
    check(in_route, {23{5'h1F}});
    check(out_route, '0);
    check(pin_in, '0);
    check(oe, '0);
    for (int k = 0; k < 64; k++) begin
      wr_out(0, 5'(k));
      wr_out(NP-1, 5'(k));
      wr_out(k % NP, 5'($urandom_range(31)));
      {po, ir} = 21'($urandom);
      ir.enable = {2{k[5]}};
      {latch, par_d, sp_d} = {26'($urandom), 26'($urandom), 26'($urandom)};
      {dir, par_oe, sp_oe} = {26'($urandom), 26'($urandom & $urandom), 26'($urandom & $urandom)};
      @(negedge clk);
      for (int p = 0; p < NP; p++) begin
        r = remap(codes[p]);
        e_oe[p] = sp_oe[p] | r[1] | par_oe[p] | !dir[p];
        e_d[p] = sp_oe[p] ? sp_d[p] : r[1] ? r[0] : par_oe[p] ? par_d[p] : latch[p];
      end
      check(oe, e_oe);
      check(dout, e_d);
    end
    lock = 1'b1;
    wr_in(0, 5'h03);
    wr_out(0, 5'h05);
    lock = 1'b0;
    {dir, par_oe, sp_oe} = {{NP{1'b1}}, 52'h0};
    for (int p = 0; p < NP; p++) wr_out(p, 5'h00);
    for (int rd = 0; rd < 4; rd++) begin
      for (int i = 0; i < 23; i++)
        wr_in(i, rd == 2 ? 5'(26 + i % 6) : (i < 2 && rd != 0) ? 5'h00 : 5'($urandom_range(25)));
      {ana, ext} = {26'($urandom), 26'($urandom)};
      ana[0] = (rd == 3);
      repeat (7) @(negedge clk);
      for (int i = 0; i < 23; i++) e_in[i] = (fld[i] < NP && !ana[fld[i]]) ? ext[fld[i]] : 1'b0;
      check(pin_in, e_in);
      check(oe, '0);
    end
    give_verdict;
  end
endmodule  // testbench
